// [rtl/charge_supervision_params.svh]
// Constants of the charger supervision block: offsets, reset values, times.
// Assumes a 50 MHz logic clock and 32-bit classic Wishbone access.
`ifndef CHARGE_SUPERVISION_PARAMS_SVH
`define CHARGE_SUPERVISION_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CST_ADR_CTRL 8'h00
`define CST_ADR_TARGET 8'h04
`define CST_ADR_VREG 8'h08
`define CST_ADR_BUTTON 8'h0C
`define CST_ADR_STATUS 8'h10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CST_CTRL_RST 6'h05
`define CST_TARGET_RST 8'h0A
`define CST_VREG_RST 16'h1068
`define CST_BUTTON_RST 8'h00

// ----------------------------------------------------------------------
// Times and levels
// ----------------------------------------------------------------------
`define CST_CLK_PERIOD_NS 20
`define CST_US_NS 1000
`define CST_HALF_S_US 500000
`define CST_WDOG_S 50
`define CST_IRQ_PULSE_US 128
`define CST_PRE_DIVISOR 10
`define CST_TMR0_S 1800
`define CST_TMR1_S 3600
`define CST_TMR2_S 10800
`define CST_TMR3_S 21600
`define CST_WARM_DROP_MV 140
`define CST_VREG_FLOOR_MV 3600

`endif

// [rtl/charge_supervision_pkg.sv]
// Types shared by the charger supervision block.
// Assumes the constants header is on the include path.
package charge_supervision_pkg;

   // Digital results of the analog side, all asynchronous to clk_i
   typedef struct packed {
      logic chip_off_n;
      logic push_button_n;
      logic load_switch_pin;
      logic vin_present;
      logic vin_above_uvlo;
      logic vin_above_bat_slp;
      logic vin_below_ovp;
      logic ts_beyond_hot;
      logic ts_warm;
      logic ts_cool;
      logic ts_beyond_cold;
      logic ts_off;
      logic die_shutdown;
      logic charge_terminated;
      logic precharge_phase;
      logic alt_loop_active;
      logic startup_done;
      logic startup_fault;
   } pins_t;

   typedef struct packed {
      logic charge_enable;
      logic mid_supply_en;
      logic system_en;
      logic aux_en;
      logic batt_discharge_on;
   } supply_t;

   typedef struct packed {
      logic aux_enable;
      logic good_pin_as_button_mirror;
      logic [1:0] safety_duration_sel;
      logic double_period_enable;
      logic irq_status_enable;
   } ctrl_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_PRE, ST_FAST, ST_DONE, ST_FAULT
   } charge_state_t;

endpackage

// [rtl/charge_supervision_timers.sv]
// Charger supervision: safety timer, host watchdog, thermistor zones,
// thermal shutdown, power-good and interrupt pins, chip-off behaviour.
// Assumes asynchronous pin inputs and a classic Wishbone master.
//
// Operation
// - Safety timer starts; expiry stops charging
// - Precharge limited to one tenth
// - Safety fault: one 128 us irq pulse
// - Fault cleared only by chip-off toggle, power
// - Duration select change restarts running timer
// - Half-rate timer on other regulation loops
// - 50 s watchdog armed by first transaction
// - High impedance holds watchdog disarmed until next transaction after it ends
// - Each host transaction outside high impedance restarts the watchdog
// - Watchdog expiry resets registers except button
// - Hot or cold suspends charging, pauses safety timer
// - Cool zone halves charge current
// - Warm zone drops voltage 140 mV, floor 3.6V
// - Thermistor off threshold ignores zones
// - Die shutdown stops charging and outputs
// - Shutdown holds safety timer reset, watchdog runs
// - Status only after valid start-up
// - Outside mirror mode, power good low only for valid input
// - Mirror mode: power good follows button
// - Irq low while charging when enabled
// - Battery only, chip off: high impedance mode
// - Input present: chip_off_n low enables charging
`timescale 1ns/10ps
`include "charge_supervision_params.svh"

module charge_supervision_timers
#(
   parameter int unsigned HALF_S_US = `CST_HALF_S_US,
   parameter int unsigned IRQ_PULSE_CYC =
      `CST_IRQ_PULSE_US * `CST_US_NS / `CST_CLK_PERIOD_NS,
   parameter int unsigned WDOG_S = `CST_WDOG_S,
   parameter int unsigned TMR0_S = `CST_TMR0_S,
   parameter int unsigned TMR1_S = `CST_TMR1_S,
   parameter int unsigned TMR2_S = `CST_TMR2_S,
   parameter int unsigned TMR3_S = `CST_TMR3_S
)
(
   input logic clk_i,
   input logic rst_i,
   input logic cyc_i,
   input logic stb_i,
   input logic we_i,
   input logic [7:0] adr_i,
   input logic [3:0] sel_i,
   input logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input charge_supervision_pkg::pins_t pins_i,
   output charge_supervision_pkg::supply_t supply_o,
   output logic [7:0] charge_current_target_o,
   output logic [15:0] vreg_target_mv_o,
   input logic irq_line_i,
   output logic irq_line_o,
   output logic irq_line_oe_o,
   input logic power_good_n_i,
   output logic power_good_n_o,
   output logic power_good_n_oe_o
);
   import charge_supervision_pkg::*;

   localparam int unsigned US_CYC = `CST_US_NS / `CST_CLK_PERIOD_NS;
   localparam logic [7:0] WD_HALVES = 8'(2 * WDOG_S);

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   pins_t sync1;
   pins_t p;
   pins_t p_d;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1 <= '0;
         p <= '0;
         p_d <= '0;
      end
      else
      begin
         sync1 <= pins_i;
         p <= sync1;
         p_d <= p;
      end
   end

   wire status_valid = p.startup_done & ~p.startup_fault;
   wire thermal = p.die_shutdown;
   wire hiz = ~p.vin_present & ~p.chip_off_n;
   wire charge_req = p.vin_present & ~p.chip_off_n & status_valid;
   wire ts_on = ~p.ts_off;
   wire ts_suspend = ts_on & (p.ts_beyond_hot | p.ts_beyond_cold);
   wire ts_cool_zone = ts_on & p.ts_cool & ~p.ts_beyond_cold;
   wire ts_warm_zone = ts_on & p.ts_warm & ~p.ts_beyond_hot;
   wire fault_clear = (p.chip_off_n ^ p_d.chip_off_n)
      | (p_d.vin_present & ~p.vin_present);

   // -------------------------------------------------------------------
   // Timebase
   // -------------------------------------------------------------------
   logic [5:0] cyc_cnt;
   logic [19:0] us_cnt;
   logic half_phase;
   wire us_tick = cyc_cnt == 6'(US_CYC - 1);
   wire half_tick = us_tick & (us_cnt == 20'(HALF_S_US - 1));

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cyc_cnt <= '0;
         us_cnt <= '0;
         half_phase <= 1'b0;
      end
      else
      begin
         cyc_cnt <= us_tick ? 6'h0 : cyc_cnt + 6'h1;
         if (us_tick)
            us_cnt <= half_tick ? 20'h0_0000 : us_cnt + 20'h0_0001;
         if (half_tick)
            half_phase <= ~half_phase;
      end
   end

   // -------------------------------------------------------------------
   // Wishbone slave and registers
   // -------------------------------------------------------------------
   ctrl_t ctrl;
   logic [7:0] target;
   logic [15:0] vreg;
   logic [7:0] button;
   logic wd_expire;
   charge_state_t state;
   logic err_safety;
   logic err_thermal;
   logic err_ts;
   logic wd_armed;

   wire req = cyc_i & stb_i & ~ack_o;
   wire wr = req & we_i;
   wire hit_ctrl = adr_i == `CST_ADR_CTRL;
   wire hit_target = adr_i == `CST_ADR_TARGET;
   wire hit_vreg = adr_i == `CST_ADR_VREG;
   wire hit_button = adr_i == `CST_ADR_BUTTON;
   wire hit_status = adr_i == `CST_ADR_STATUS;
   wire wr_ctrl = wr & hit_ctrl & sel_i[0];
   wire ctrl_t new_ctrl = ctrl_t'(dat_i[5:0]);
   wire running = (state == ST_PRE) | (state == ST_FAST);
   wire sel_restart = wr_ctrl & running
      & (new_ctrl.safety_duration_sel != ctrl.safety_duration_sel);
   wire soft_rst = rst_i | wd_expire;

   wire [1:0] state_field = (state == ST_FAULT) ? 2'h3 :
      (state == ST_DONE) ? 2'h2 : running ? 2'h1 : 2'h0;
   wire [31:0] status_word = {25'h000_0000, hiz, wd_armed, err_ts,
      err_thermal, err_safety, state_field};
   wire [31:0] rd_mux =
      hit_ctrl ? {26'h000_0000, ctrl} :
      hit_target ? {24'h00_0000, target} :
      hit_vreg ? {16'h0000, vreg} :
      hit_button ? {24'h00_0000, button} :
      hit_status ? status_word : 32'h0000_0000;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end
      else
      begin
         ack_o <= req;
         dat_o <= req ? rd_mux : 32'h0000_0000;
      end
   end

   // Expiry returns everything but the button settings to default
   always_ff @(posedge clk_i)
   begin
      if (soft_rst)
      begin
         ctrl <= ctrl_t'(`CST_CTRL_RST);
         target <= `CST_TARGET_RST;
         vreg <= `CST_VREG_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= new_ctrl;
         if (wr & hit_target & sel_i[0])
            target <= dat_i[7:0];
         if (wr & hit_vreg & sel_i[0])
            vreg[7:0] <= dat_i[7:0];
         if (wr & hit_vreg & sel_i[1])
            vreg[15:8] <= dat_i[15:8];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         button <= `CST_BUTTON_RST;
      else if (wr & hit_button & sel_i[0])
         button <= dat_i[7:0];
   end

   // -------------------------------------------------------------------
   // Host watchdog
   // -------------------------------------------------------------------
   logic [7:0] wd_cnt;
   assign wd_expire = wd_armed & half_tick & (wd_cnt == WD_HALVES - 8'h01);

   // Thermal shutdown deliberately not in this path
   always_ff @(posedge clk_i)
   begin
      if (rst_i | hiz | wd_expire)
      begin
         wd_armed <= 1'b0;
         wd_cnt <= '0;
      end
      else if (ack_o)
      begin
         wd_armed <= 1'b1;
         wd_cnt <= '0;
      end
      else if (wd_armed & half_tick)
         wd_cnt <= wd_cnt + 8'h01;
   end

   // -------------------------------------------------------------------
   // Safety timer, counted in half seconds
   // -------------------------------------------------------------------
   charge_state_t next_state;
   logic [16:0] safety_cnt;
   logic [15:0] dur_s;

   always_comb
   begin
      unique case (ctrl.safety_duration_sel)
         2'd0: dur_s = 16'(TMR0_S);
         2'd1: dur_s = 16'(TMR1_S);
         2'd2: dur_s = 16'(TMR2_S);
         2'd3: dur_s = 16'(TMR3_S);
      endcase
   end

   wire [16:0] fast_lim = {dur_s, 1'b0};
   wire [16:0] pre_lim = 17'(fast_lim / 17'(`CST_PRE_DIVISOR));
   wire expired = (state == ST_PRE) ? (safety_cnt >= pre_lim)
      : (safety_cnt >= fast_lim);
   wire slow = ctrl.double_period_enable & p.alt_loop_active;
   wire step = half_tick & (~slow | half_phase) & ~ts_suspend;

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:
            if (charge_req & ~thermal & ~p.charge_terminated)
               next_state = p.precharge_phase ? ST_PRE : ST_FAST;
         ST_PRE, ST_FAST:
            if (~charge_req)
               next_state = ST_IDLE;
            else if (p.charge_terminated)
               next_state = ST_DONE;
            else if (expired)
               next_state = ST_FAULT;
            else if ((state == ST_PRE) & ~p.precharge_phase)
               next_state = ST_FAST;
         ST_DONE:
            if (~charge_req | ~p.charge_terminated)
               next_state = ST_IDLE;
         ST_FAULT:
            if (fault_clear)
               next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Precharge time counts toward the overall limit
   always_ff @(posedge clk_i)
   begin
      if (rst_i | (state == ST_IDLE) | thermal | sel_restart)
         safety_cnt <= '0;
      else if (running & step & ~expired)
         safety_cnt <= safety_cnt + 17'h0_0001;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         err_safety <= 1'b0;
         err_thermal <= 1'b0;
         err_ts <= 1'b0;
      end
      else
      begin
         err_safety <= next_state == ST_FAULT;
         err_thermal <= thermal;
         err_ts <= ts_suspend;
      end
   end

   // -------------------------------------------------------------------
   // Interrupt pulse and status pins
   // -------------------------------------------------------------------
   logic [12:0] pulse_cnt;
   logic ts_suspend_d;
   wire pulse_act = pulse_cnt != 13'h0000;
   wire fault_evt = status_valid & (((next_state == ST_FAULT)
      & (state != ST_FAULT)) | (thermal & ~p_d.die_shutdown)
      | (ts_suspend & ~ts_suspend_d));
   wire charging_low = ctrl.irq_status_enable & status_valid & running;

   // Faults during a pulse merge into it, so one pulse per burst
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pulse_cnt <= '0;
         ts_suspend_d <= 1'b0;
      end
      else
      begin
         ts_suspend_d <= ts_suspend;
         if (pulse_act)
            pulse_cnt <= pulse_cnt - 13'h0001;
         else if (fault_evt)
            pulse_cnt <= 13'(IRQ_PULSE_CYC);
      end
   end

   wire pg_input_ok = p.vin_above_uvlo & p.vin_above_bat_slp
      & p.vin_below_ovp;
   wire pg_low = status_valid & (ctrl.good_pin_as_button_mirror
      ? ~p.push_button_n : pg_input_ok);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_line_oe_o <= 1'b0;
         power_good_n_oe_o <= 1'b0;
      end
      else
      begin
         irq_line_oe_o <= pulse_act | charging_low;
         power_good_n_oe_o <= pg_low;
      end
   end

   // Open-drain pins only ever pull low
   assign irq_line_o = 1'b0;
   assign power_good_n_o = 1'b0;

   // -------------------------------------------------------------------
   // Supply control and regulation targets
   // -------------------------------------------------------------------
   wire [15:0] warm_v = (vreg >= 16'(`CST_VREG_FLOOR_MV + `CST_WARM_DROP_MV))
      ? vreg - 16'(`CST_WARM_DROP_MV) : 16'(`CST_VREG_FLOOR_MV);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         supply_o <= '0;
         charge_current_target_o <= '0;
         vreg_target_mv_o <= '0;
      end
      else
      begin
         supply_o.charge_enable <= running & ~thermal & ~ts_suspend;
         supply_o.mid_supply_en <= ~thermal;
         supply_o.system_en <= ~thermal;
         supply_o.aux_en <= ~thermal
            & (ctrl.aux_enable | p.load_switch_pin);
         supply_o.batt_discharge_on <= hiz;
         charge_current_target_o <= ts_cool_zone
            ? {1'b0, target[7:1]} : target;
         vreg_target_mv_o <= ts_warm_zone ? warm_v : vreg;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [12:0] pulse_len;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pulse_len <= '0;
      else
         pulse_len <= pulse_act ? pulse_len + 13'h0001 : 13'h0000;
   end

   sequence pg_cond_s;
      status_valid & ~ctrl.good_pin_as_button_mirror & pg_input_ok;
   endsequence

   sequence shutdown_s;
      thermal ##1 thermal;
   endsequence

   a_fault_stops_charge: assert property (
      (state == ST_FAULT) |=> ~supply_o.charge_enable)
      else $error("charging enabled in safety fault");
   a_precharge_limit: assert property (
      (state == ST_PRE) |-> (safety_cnt <= pre_lim))
      else $error("precharge ran past its limit");
   a_irq_pulse_len: assert property (
      $fell(pulse_act) |-> (pulse_len == 13'(IRQ_PULSE_CYC)))
      else $error("irq pulse length wrong");
   a_fault_held: assert property (
      (state == ST_FAULT) & ~fault_clear |=> (state == ST_FAULT))
      else $error("safety fault cleared without toggle");
   a_sel_restart: assert property (
      sel_restart |=> (safety_cnt == 17'h0_0000))
      else $error("timer not restarted on duration change");
   a_hiz_disarm: assert property (
      hiz |=> ~wd_armed ##1 (~wd_armed | $past(ack_o)))
      else $error("watchdog armed in high impedance");
   a_wd_kick: assert property (
      ack_o & ~hiz & ~wd_expire |=> wd_armed & (wd_cnt == 8'h00))
      else $error("transaction did not restart watchdog");
   a_wd_reset_regs: assert property (
      wd_expire & ~wr |=> (ctrl == ctrl_t'(`CST_CTRL_RST))
      & (button == $past(button)))
      else $error("watchdog expiry reset wrong registers");
   a_ts_pause: assert property (
      running & ts_suspend & ~thermal & ~sel_restart & (next_state == state)
      |=> (safety_cnt == $past(safety_cnt)))
      else $error("safety timer ran while temperature out of range");
   a_shutdown_out: assert property (
      shutdown_s |-> ~supply_o.mid_supply_en & ~supply_o.system_en
      & ~supply_o.charge_enable & (safety_cnt == 17'h0_0000))
      else $error("outputs active in thermal shutdown");
   a_no_irq_invalid: assert property (
      ~status_valid & ~pulse_act |=> ~pulse_act)
      else $error("irq pulse without valid start-up");
   a_pg_drive: assert property (
      pg_cond_s |=> power_good_n_oe_o)
      else $error("power good not driven for valid input");
   a_cd_charge: assert property (
      supply_o.charge_enable |-> $past(p.vin_present & ~p.chip_off_n, 2))
      else $error("charging without input and chip_off_n low");

endmodule // charge_supervision_timers

// [tb/wb_host.sv]
// Host model: classic Wishbone master doing single-word accesses.
// Assumes it shares the block's clock; ack may come after any delay.
`timescale 1ns/10ps

module wb_host
(
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   initial
   begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h0;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end

   // Request held until ack; next call waits an edge, so one idle cycle
   // Only the bench watchdog ends a wait for a missing ack
   task automatic xfer(input logic we, input logic [7:0] adr,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= we;
      adr_o <= adr;
      sel_o <= 4'hf;
      dat_o <= wd;
      do
         @(posedge clk_i);
      while (ack_i !== 1'b1);
      rd = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
   endtask
endmodule // wb_host

// [tb/charge_supervision_timers_test.sv]
// Bench for the charger supervision block with shortened timebase.
// Assumes the host model and the constants header on the include path.
`timescale 1ns/10ps
`include "charge_supervision_params.svh"

module charge_supervision_timers_test;
   import charge_supervision_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, irq_oe, pg_oe;
   logic [7:0] adr, cur;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, d;
   logic [15:0] vreg;
   pins_t pins;
   supply_t sup;
   int mismatches = 0;
   int n_tests = 0;
   int irq_cnt = 0;

   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) if (irq_oe === 1'b1) irq_cnt <= irq_cnt + 1;

   wb_host u_wb_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
      .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wdat));

   // Half second is 250 clocks, watchdog 6 of them, default limit 80
   charge_supervision_timers #(.HALF_S_US(5), .IRQ_PULSE_CYC(16),
      .WDOG_S(3), .TMR0_S(20), .TMR1_S(40), .TMR2_S(60), .TMR3_S(80))
   u_charge_supervision_timers (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pins_i(pins),
      .supply_o(sup), .charge_current_target_o(cur),
      .vreg_target_mv_o(vreg), .irq_line_i(~irq_oe), .irq_line_o(),
      .irq_line_oe_o(irq_oe), .power_good_n_i(~pg_oe), .power_good_n_o(),
      .power_good_n_oe_o(pg_oe));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      u_wb_host.xfer(1'b1, a, v, x);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      u_wb_host.xfer(1'b0, a, 32'h0, x);
      chk(nm, e, x & m);
   endtask

   task automatic settle;
      repeat (6) @(posedge clk_i);
   endtask

   // Waits in 500-cycle steps, pinging so the watchdog stays quiet
   task automatic idle(input int k);
      logic [31:0] x;
      repeat (k)
      begin
         repeat (500) @(posedge clk_i);
         u_wb_host.xfer(1'b0, `CST_ADR_BUTTON, 32'h0, x);
      end
   endtask

   task automatic toggle_off;
      pins.chip_off_n <= 1'b1;
      settle();
      pins.chip_off_n <= 1'b0;
      settle();
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (70000) @(posedge clk_i);
      mismatches++;
      close_out();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      pins = '0;
      pins.chip_off_n = 1'b1;
      pins.push_button_n = 1'b1;
      pins.vin_present = 1'b1;
      pins.vin_above_uvlo = 1'b1;
      pins.vin_above_bat_slp = 1'b1;
      pins.vin_below_ovp = 1'b1;
      pins.startup_done = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rchk("ctrl", `CST_ADR_CTRL, 32'hff, 32'h5);
      rchk("target", `CST_ADR_TARGET, 32'hff, 32'ha);
      rchk("vreg", `CST_ADR_VREG, 32'hffff, 32'h1068);
      rchk("button", `CST_ADR_BUTTON, 32'hff, 32'h0);
      rchk("unmapped", 8'h14, 32'hffff_ffff, 32'h0);
      $display("test reset values done");

      wr(`CST_ADR_TARGET, 32'h33);
      wr(`CST_ADR_BUTTON, 32'ha5);
      repeat (1200) @(posedge clk_i);
      rchk("target kept", `CST_ADR_TARGET, 32'hff, 32'h33);
      repeat (1800) @(posedge clk_i);
      rchk("target expiry", `CST_ADR_TARGET, 32'hff, 32'ha);
      rchk("button kept", `CST_ADR_BUTTON, 32'hff, 32'ha5);
      $display("test watchdog done");

      pins.vin_present <= 1'b0;
      pins.chip_off_n <= 1'b0;
      settle();
      chk("hiz supply", 32'hd, {27'h0, sup} & 32'h1d);
      pins.load_switch_pin <= 1'b1;
      settle();
      chk("hiz ls", 32'h1, {31'h0, sup.aux_en});
      pins.load_switch_pin <= 1'b0;
      rchk("hiz status", `CST_ADR_STATUS, 32'h40, 32'h40);
      wr(`CST_ADR_TARGET, 32'h33);
      repeat (2000) @(posedge clk_i);
      rchk("hiz no expiry", `CST_ADR_TARGET, 32'hff, 32'h33);
      pins.vin_present <= 1'b1;
      pins.chip_off_n <= 1'b1;
      settle();
      $display("test high impedance done");

      wr(`CST_ADR_TARGET, 32'h14);
      pins.ts_cool <= 1'b1;
      settle();
      chk("cool", 32'ha, {24'h0, cur});
      pins.ts_off <= 1'b1;
      settle();
      chk("ts off", 32'h14, {24'h0, cur});
      pins.ts_cool <= 1'b0;
      pins.ts_off <= 1'b0;
      pins.ts_warm <= 1'b1;
      settle();
      chk("warm", 32'hfdc, {16'h0, vreg});
      wr(`CST_ADR_VREG, 32'he42);
      settle();
      chk("warm floor", 32'he10, {16'h0, vreg});
      pins.ts_warm <= 1'b0;
      $display("test zones done");

      pins.chip_off_n <= 1'b0;
      settle();
      chk("charge on", 32'h1, {31'h0, sup.charge_enable});
      chk("irq level", 32'h1, {31'h0, irq_oe});
      pins.ts_beyond_hot <= 1'b1;
      settle();
      chk("hot", 32'h0, {31'h0, sup.charge_enable});
      pins.ts_beyond_hot <= 1'b0;
      pins.ts_beyond_cold <= 1'b1;
      settle();
      chk("cold", 32'h0, {31'h0, sup.charge_enable});
      pins.ts_beyond_cold <= 1'b0;
      pins.die_shutdown <= 1'b1;
      settle();
      chk("die", 32'h0, {27'h0, sup} & 32'h1e);
      pins.die_shutdown <= 1'b0;
      settle();
      chk("die resume", 32'h1, {31'h0, sup.charge_enable});
      pins.charge_terminated <= 1'b1;
      settle();
      chk("terminated", 32'h0, {31'h0, sup.charge_enable});
      pins.charge_terminated <= 1'b0;
      settle();
      pins.chip_off_n <= 1'b1;
      repeat (30) @(posedge clk_i);
      chk("charge off", 32'h0, {31'h0, sup.charge_enable});
      chk("irq float", 32'h0, {31'h0, irq_oe});
      $display("test charging pins done");

      chk("pg valid", 32'h1, {31'h0, pg_oe});
      pins.vin_below_ovp <= 1'b0;
      settle();
      chk("pg ovp", 32'h0, {31'h0, pg_oe});
      pins.vin_below_ovp <= 1'b1;
      pins.startup_done <= 1'b0;
      settle();
      chk("pg startup", 32'h0, {31'h0, pg_oe});
      pins.startup_done <= 1'b1;
      pins.startup_fault <= 1'b1;
      settle();
      chk("pg start fault", 32'h0, {31'h0, pg_oe});
      pins.startup_fault <= 1'b0;
      pins.vin_above_uvlo <= 1'b0;
      settle();
      chk("pg uvlo", 32'h0, {31'h0, pg_oe});
      pins.vin_above_uvlo <= 1'b1;
      wr(`CST_ADR_CTRL, 32'h15);
      pins.push_button_n <= 1'b0;
      settle();
      chk("mirror low", 32'h1, {31'h0, pg_oe});
      pins.push_button_n <= 1'b1;
      settle();
      chk("mirror high", 32'h0, {31'h0, pg_oe});
      $display("test power good done");

      // Level indication off so only fault pulses reach the counter
      wr(`CST_ADR_CTRL, 32'h4);
      pins.precharge_phase <= 1'b1;
      pins.chip_off_n <= 1'b0;
      settle();
      irq_cnt = 0;
      idle(3);
      chk("pre running", 32'h1, {31'h0, sup.charge_enable});
      idle(2);
      chk("pre limit", 32'h0, {31'h0, sup.charge_enable});
      chk("fault pulse", 32'd16, irq_cnt);
      rchk("fault status", `CST_ADR_STATUS, 32'h7, 32'h7);
      wr(`CST_ADR_CTRL, 32'h4);
      idle(2);
      chk("fault held", 32'h0, {31'h0, sup.charge_enable});
      pins.precharge_phase <= 1'b0;
      toggle_off();
      chk("fault clear", 32'h1, {31'h0, sup.charge_enable});
      idle(38);
      chk("fast running", 32'h1, {31'h0, sup.charge_enable});
      idle(4);
      chk("fast limit", 32'h0, {31'h0, sup.charge_enable});
      $display("test safety timer done");

      wr(`CST_ADR_CTRL, 32'h6);
      pins.alt_loop_active <= 1'b1;
      pins.precharge_phase <= 1'b1;
      toggle_off();
      idle(6);
      chk("half rate", 32'h1, {31'h0, sup.charge_enable});
      idle(4);
      chk("half limit", 32'h0, {31'h0, sup.charge_enable});
      $display("test half rate done");
      close_out();
   end
endmodule // charge_supervision_timers_test
